// ### hdl/cesg_top.sv
`timescale 1ns/1ps
`default_nettype none

module cesg_top
  import cesg_pkg::*;
#(
  parameter int DET_DELAY = DET_DELAY_CYC,
  parameter int SS_STEP   = SS_STEP_CYC,
  parameter int PROG_W    = 8
)(
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rstn_i,
  // Host enable and conditions
  input  wire logic              charge_enable_low_input_i,
  input  wire cesg_cond_t        cond_i,
  input  wire logic [7:0]        die_temp_c_i,
  // Regulation inputs
  input  wire logic [PROG_W-1:0] prog_current_i,
  input  wire logic [5:0]        error_amp_output_i,
  input  wire logic              above_sync_threshold_i,
  input  wire logic              bootstrap_low_i,
  // Status
  output logic                   charging_o,
  output logic                   thermal_shutdown_o,
  output logic                   sync_mode_o,
  output logic [PROG_W-1:0]      iref_o,
  // Gate drives
  output logic                   hs_drive_o,
  output logic                   low_side_drive_o
);

  // ---------------------------------------------------------------
  // Thermal flag with hysteresis
  // ---------------------------------------------------------------
  logic therm_reg;
  logic therm_next;

  wire logic temp_hot  = (die_temp_c_i >= THERM_RISE_C);
  wire logic temp_cool = (die_temp_c_i <= THERM_FALL_C);

  assign therm_next = temp_hot ? 1'b1
                    : (temp_cool ? 1'b0 : therm_reg);

  // ---------------------------------------------------------------
  // Post-detect delay
  // ---------------------------------------------------------------
  logic [23:0] det_cnt_reg;
  logic [23:0] det_cnt_next;
  logic        det_done;

  // Detect input is the 2.4 V comparator level
  wire logic adapter_det = cond_i.adapter_detect_input;

  assign det_done     = (det_cnt_reg >= 24'(DET_DELAY));
  assign det_cnt_next = !adapter_det ? 24'h000000
                      : (det_done ? det_cnt_reg
                                  : det_cnt_reg + 24'h000001);

  // ---------------------------------------------------------------
  // Charge enable qualification
  // ---------------------------------------------------------------
  logic chg_reg;
  logic chg_next;

  wire logic stop_cond = charge_enable_low_input_i
                       | !cond_i.supply_ok
                       | !adapter_det
                       | !cond_i.adapter_headroom_ok
                       | cond_i.adapter_ovp
                       | cond_i.adapter_ocp
                       | therm_reg;

  wire logic start_cond = !stop_cond
                        & det_done
                        & cond_i.regulator_ok
                        & cond_i.reference_ok;

  assign chg_next = chg_reg ? !stop_cond : start_cond;

  // ---------------------------------------------------------------
  // Soft-start of the current reference
  // ---------------------------------------------------------------
  logic [3:0]          step_reg;
  logic [3:0]          step_next;
  logic [23:0]         ss_tmr_reg;
  logic [23:0]         ss_tmr_next;
  logic [PROG_W-1:0]   iref_reg;
  logic [PROG_W-1:0]   iref_next;
  logic [PROG_W+3:0]   iref_prod;

  wire logic ss_full = (step_reg == 4'(SS_STEPS));
  wire logic ss_tick = (ss_tmr_reg >= 24'(SS_STEP - 1));

  always_comb begin
    step_next   = step_reg;
    ss_tmr_next = ss_tmr_reg;
    if (!chg_next) begin
      step_next   = SS_STEP_RST;
      ss_tmr_next = 24'h000000;
    end else if (step_reg == SS_STEP_RST) begin
      step_next   = 4'h1;
      ss_tmr_next = 24'h000000;
    end else if (!ss_full) begin
      if (ss_tick) begin
        step_next   = step_reg + 4'h1;
        ss_tmr_next = 24'h000000;
      end else begin
        ss_tmr_next = ss_tmr_reg + 24'h000001;
      end
    end
  end

  assign iref_prod = prog_current_i * step_reg;
  assign iref_next = iref_prod[PROG_W+2:3];

  // ---------------------------------------------------------------
  // Fixed-frequency ramp
  // ---------------------------------------------------------------
  logic [5:0] ramp_reg;
  logic [5:0] ramp_next;

  wire logic cyc_start = (ramp_reg == 6'h00);

  assign ramp_next = (ramp_reg == 6'(PWM_PERIOD_CYC - 1)) ? 6'h00
                   : ramp_reg + 6'h01;

  // Duty request: above ramp turns high side on
  wire logic duty_req = (error_amp_output_i > ramp_reg);

  // ---------------------------------------------------------------
  // Bootstrap watchdog and refresh
  // ---------------------------------------------------------------
  logic [2:0] bst_cnt_reg;
  logic [2:0] bst_cnt_next;
  logic [5:0] ref_tmr_reg;
  logic [5:0] ref_tmr_next;
  logic       hs_on;

  wire logic refreshing = (ref_tmr_reg != 6'h00);
  wire logic bst_trip   = cyc_start && bootstrap_low_i
                        && (bst_cnt_reg >= 3'(BST_LOW_MAX)) && hs_on;

  always_comb begin
    bst_cnt_next = bst_cnt_reg;
    if (!bootstrap_low_i)
      bst_cnt_next = 3'h0;
    else if (bst_trip)
      bst_cnt_next = 3'h0;
    else if (cyc_start && bst_cnt_reg != 3'h7)
      bst_cnt_next = bst_cnt_reg + 3'h1;
  end

  assign ref_tmr_next = bst_trip ? 6'(REFRESH_CYC)
                      : (refreshing ? ref_tmr_reg - 6'h01 : 6'h00);

  // High side never starts while bootstrap is low
  wire logic hs_block = bootstrap_low_i && !hs_on;
  wire logic hs_req   = duty_req && !refreshing && !hs_block && !bst_trip;
  wire logic pulse_rq = cyc_start && bootstrap_low_i && !hs_on;

  // ---------------------------------------------------------------
  // Mode select
  // ---------------------------------------------------------------
  logic sync_reg;
  logic sync_next;

  assign sync_next = above_sync_threshold_i;
  wire logic sync_eff = sync_reg && !refreshing && !bootstrap_low_i;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      therm_reg   <= 1'b0;
      det_cnt_reg <= 24'h000000;
      chg_reg     <= 1'b0;
      step_reg    <= SS_STEP_RST;
      ss_tmr_reg  <= 24'h000000;
      iref_reg    <= '0;
      ramp_reg    <= 6'h00;
      bst_cnt_reg <= 3'h0;
      ref_tmr_reg <= 6'h00;
      sync_reg    <= 1'b0;
    end else begin
      therm_reg   <= therm_next;
      det_cnt_reg <= det_cnt_next;
      chg_reg     <= chg_next;
      step_reg    <= step_next;
      ss_tmr_reg  <= ss_tmr_next;
      iref_reg    <= iref_next;
      ramp_reg    <= ramp_next;
      bst_cnt_reg <= bst_cnt_next;
      ref_tmr_reg <= ref_tmr_next;
      sync_reg    <= sync_next;
    end
  end

  // ---------------------------------------------------------------
  // Gate sequencer
  // ---------------------------------------------------------------
  cesg_gate_seq u_gate (
    .core_clk_i       (core_clk_i),
    .rstn_i           (rstn_i),
    .run_i            (chg_reg),
    .hs_req_i         (hs_req),
    .sync_i           (sync_eff),
    .pulse_req_i      (pulse_rq),
    .hs_drive_o       (hs_on),
    .low_side_drive_o (low_side_drive_o)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign hs_drive_o         = hs_on;
  assign charging_o         = chg_reg;
  assign thermal_shutdown_o = therm_reg;
  assign sync_mode_o        = sync_reg;
  assign iref_o             = iref_reg;

endmodule : cesg_top

`default_nettype wire

// ### hdl/cesg_pkg.sv
`default_nettype none

package cesg_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ         = 10;
  localparam int CLK_KHZ         = CLK_MHZ * 1000;
  localparam int PWM_KHZ         = 300;
  localparam int PWM_PERIOD_CYC  = CLK_KHZ / PWM_KHZ;
  localparam int DEAD_NS         = 30;
  localparam int DEAD_CYC_RAW    = (DEAD_NS * CLK_MHZ + 999) / 1000;
  localparam int DEAD_CYC        = (DEAD_CYC_RAW < 1) ? 1 : DEAD_CYC_RAW;
  localparam int PULSE_NS        = 80;
  localparam int PULSE_CYC_RAW   = (PULSE_NS * CLK_MHZ + 500) / 1000;
  localparam int PULSE_CYC       = (PULSE_CYC_RAW < 1) ? 1 : PULSE_CYC_RAW;
  localparam int SS_STEP_US      = 1700;
  localparam int SS_STEP_CYC     = SS_STEP_US * CLK_MHZ;
  localparam int DET_DELAY_MS    = 1200;
  localparam int DET_DELAY_CYC   = DET_DELAY_MS * 1000 * CLK_MHZ;
  localparam int SS_STEPS        = 8;
  localparam int BST_LOW_MAX     = 3;
  localparam int REFRESH_CYC     = 2 * DEAD_CYC + PULSE_CYC + 1;

  // ---------------------------------------------------------------
  // Thermal thresholds in degrees C
  // ---------------------------------------------------------------
  localparam logic [7:0] THERM_RISE_C = 8'h9b;
  localparam logic [7:0] THERM_HYST_C = 8'h14;
  localparam logic [7:0] THERM_FALL_C = THERM_RISE_C - THERM_HYST_C;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] SS_STEP_RST = 4'h0;

  // ---------------------------------------------------------------
  // Qualifying conditions from the analog front end
  // ---------------------------------------------------------------
  typedef struct packed {
    logic supply_ok;
    logic adapter_detect_input;
    logic adapter_headroom_ok;
    logic adapter_ovp;
    logic adapter_ocp;
    logic regulator_ok;
    logic reference_ok;
  } cesg_cond_t;

  // ---------------------------------------------------------------
  // Gate sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    GS_OFF,
    GS_HS,
    GS_BBM,
    GS_LS,
    GS_PULSE
  } cesg_gate_st_t;

endpackage : cesg_pkg

`default_nettype wire

// ### hdl/cesg_gate_seq.sv
`timescale 1ns/1ps
`default_nettype none

module cesg_gate_seq
  import cesg_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  // Requests
  input  wire logic run_i,
  input  wire logic hs_req_i,
  input  wire logic sync_i,
  input  wire logic pulse_req_i,
  // Drives
  output logic      hs_drive_o,
  output logic      low_side_drive_o
);

  // ---------------------------------------------------------------
  // State and timer
  // ---------------------------------------------------------------
  cesg_gate_st_t st_reg;
  cesg_gate_st_t st_next;
  logic [7:0]    tmr_reg;
  logic [7:0]    tmr_next;
  logic          hs_reg;
  logic          ls_reg;

  wire logic dead_done  = (tmr_reg >= 8'(DEAD_CYC - 1));
  wire logic pulse_done = (tmr_reg >= 8'(PULSE_CYC - 1));

  // ---------------------------------------------------------------
  // Break-before-make sequencing
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      GS_OFF: begin
        if (run_i && hs_req_i && dead_done)
          st_next = GS_HS;
        else if (run_i && pulse_req_i && dead_done)
          st_next = GS_PULSE;
      end
      GS_HS: begin
        if (!run_i || !hs_req_i)
          st_next = GS_BBM;
      end
      GS_BBM: begin
        if (dead_done) begin
          if (!run_i)
            st_next = GS_OFF;
          else if (sync_i)
            st_next = GS_LS;
          else
            st_next = GS_PULSE;
        end
      end
      GS_LS: begin
        if (!run_i || hs_req_i || !sync_i)
          st_next = GS_OFF;
      end
      GS_PULSE: begin
        if (pulse_done || !run_i)
          st_next = GS_OFF;
      end
      default: st_next = GS_OFF;
    endcase
  end

  assign tmr_next = (st_next != st_reg) ? 8'h00
                  : ((tmr_reg == 8'hff) ? tmr_reg : tmr_reg + 8'h01);

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      st_reg  <= GS_OFF;
      tmr_reg <= 8'(DEAD_CYC);
      hs_reg  <= 1'b0;
      ls_reg  <= 1'b0;
    end else begin
      st_reg  <= st_next;
      tmr_reg <= tmr_next;
      hs_reg  <= (st_next == GS_HS);
      ls_reg  <= (st_next == GS_LS) || (st_next == GS_PULSE);
    end
  end

  assign hs_drive_o       = hs_reg;
  assign low_side_drive_o = ls_reg;

endmodule : cesg_gate_seq

`default_nettype wire

// ### tb/cesg_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Port checker
// ------------------------------
module cesg_top_chk
  import cesg_pkg::*;
#(
  parameter int PROG_W = 8
)(
  // Inputs
  input wire logic              core_clk_i,
  input wire logic              rstn_i,
  input wire logic              charge_enable_low_input_i,
  input wire cesg_cond_t        cond_i,
  input wire logic [7:0]        die_temp_c_i,
  input wire logic [PROG_W-1:0] prog_current_i,
  input wire logic [5:0]        error_amp_output_i,
  input wire logic              above_sync_threshold_i,
  // Outputs
  input wire logic              charging_o,
  input wire logic              thermal_shutdown_o,
  input wire logic              sync_mode_o,
  input wire logic [PROG_W-1:0] iref_o,
  input wire logic              hs_drive_o,
  input wire logic              low_side_drive_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  wire stop_w = charge_enable_low_input_i | ~cond_i.supply_ok |
    ~cond_i.adapter_detect_input | ~cond_i.adapter_headroom_ok |
    cond_i.adapter_ovp | cond_i.adapter_ocp | thermal_shutdown_o;
  wire start_w = ~stop_w & cond_i.regulator_ok & cond_i.reference_ok;
  sequence s_ctl_zero;
    (error_amp_output_i == 6'h00) [*4];
  endsequence
  sequence s_ls_on;
    $rose(low_side_drive_o);
  endsequence
  a_no_overlap: assert property (!(hs_drive_o && low_side_drive_o))
    else $error("both drives on");
  a_bbm_ls: assert property (s_ls_on |-> !$past(hs_drive_o))
    else $error("low side on without gap");
  a_bbm_hs: assert property ($rose(hs_drive_o) |->
    !$past(low_side_drive_o))
    else $error("high side on without gap");
  a_pulse_len: assert property (s_ls_on ##0 (!sync_mode_o &&
    !$past(sync_mode_o) && !above_sync_threshold_i) |=> !low_side_drive_o)
    else $error("pulse too long");
  a_zero_duty: assert property (s_ctl_zero |=> !hs_drive_o)
    else $error("high side on at zero control");
  a_chg_stop: assert property (charging_o && stop_w |=> !charging_o)
    else $error("charge not stopped");
  a_chg_start: assert property ($rose(charging_o) |->
    $past(start_w))
    else $error("charge started unqualified");
  a_therm_set: assert property (die_temp_c_i >= THERM_RISE_C |=>
    thermal_shutdown_o)
    else $error("thermal flag not set");
  a_therm_clr: assert property (die_temp_c_i <= THERM_FALL_C |=>
    !thermal_shutdown_o)
    else $error("thermal flag not cleared");
  a_therm_hold: assert property (thermal_shutdown_o &&
    die_temp_c_i > THERM_FALL_C |=> thermal_shutdown_o)
    else $error("thermal flag dropped early");
  a_iref_idle: assert property (!charging_o |=> iref_o == '0)
    else $error("reference not zero when idle");
  a_first_step: assert property ($rose(charging_o) |=>
    iref_o == ($past(prog_current_i) >> 3))
    else $error("first step wrong");
  a_sync_sel: assert property ($past(rstn_i) |->
    sync_mode_o == $past(above_sync_threshold_i))
    else $error("mode select wrong");
endmodule : cesg_top_chk
`default_nettype wire

// ### tb/cesg_fet_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Power stage bootstrap model
// ------------------------------
module cesg_fet_model (
  // Drives and control
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  input  wire logic hs_drive_i,
  input  wire logic ls_drive_i,
  input  wire logic force_low_i,
  // Bootstrap state
  output logic      bootstrap_low_o
);
  logic [6:0] on_cnt_reg;
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || ls_drive_i) on_cnt_reg <= 7'h00;
    else if (hs_drive_i && on_cnt_reg != 7'h7f)
      on_cnt_reg <= on_cnt_reg + 7'h01;
  end
  assign bootstrap_low_o = force_low_i | (on_cnt_reg >= 7'h46);
endmodule : cesg_fet_model
`default_nettype wire

// ### tb/cesg_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Bench
// ------------------------------
module cesg_top_bench;
  import cesg_pkg::*;
  localparam int DET = 50;
  localparam int SS = 20;
  localparam cesg_cond_t OK = 7'h73;
  logic clk = 1'b0, rstn = 1'b0, en_n = 1'b1, sync = 1'b0, force_low = 1'b0;
  cesg_cond_t cond = 7'h00;
  logic [7:0] temp = 8'h19, prog = 8'h00, iref;
  logic [5:0] error_amp_output = 6'h00;
  logic chg, tsd, smode, hs, ls, bl;
  logic [7:0] tt [4] = '{8'h9a, 8'h9b, 8'h88, 8'h87};
  logic [3:0] tf = 4'h6;
  int n_errors = 0, check_count = 0, cyc = 0, n, h, r;
  cesg_top #(.DET_DELAY(DET), .SS_STEP(SS)) u_dut (.core_clk_i(clk),
    .rstn_i(rstn), .charge_enable_low_input_i(en_n), .cond_i(cond),
    .die_temp_c_i(temp), .prog_current_i(prog), .error_amp_output_i(error_amp_output),
    .above_sync_threshold_i(sync), .bootstrap_low_i(bl), .charging_o(chg),
    .thermal_shutdown_o(tsd), .sync_mode_o(smode), .iref_o(iref),
    .hs_drive_o(hs), .low_side_drive_o(ls));
  cesg_fet_model u_fet (.core_clk_i(clk), .rstn_i(rstn), .hs_drive_i(hs),
    .ls_drive_i(ls), .force_low_i(force_low), .bootstrap_low_o(bl));
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      n_errors++;
      conclude();
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task start(output int c);
    @(posedge clk);
    cond <= OK;
    en_n <= 1'b0;
    temp <= 8'h19;
    c = 0;
    while (chg !== 1'b1 && c < 200) begin
      @(negedge clk);
      c++;
    end
  endtask : start
  task watch(input int k, output int hc, output int rc);
    logic p;
    hc = 0;
    rc = 0;
    p = ls;
    repeat (k) begin
      @(negedge clk);
      hc += (hs === 1'b1);
      rc += (ls === 1'b1 && p !== 1'b1);
      p = ls;
    end
  endtask : watch
  task rise(output int c);
    logic p;
    c = 0;
    p = hs;
    do begin
      p = hs;
      @(negedge clk);
      c++;
    end while (!(hs === 1'b1 && p !== 1'b1) && c < 300);
  endtask : rise
  task conclude;
    $display("Checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  initial begin
    void'($urandom(32'hd45edf95));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    prog <= 8'($urandom_range(255, 8));
    start(n);
    chk(8'(n >= DET && n <= DET + 3), 8'h01);
    repeat (SS / 2) @(negedge clk);
    for (int k = 1; k <= 8; k++) begin
      chk(iref, 8'((prog * k) >> 3));
      repeat (SS) @(negedge clk);
    end
    chk(iref, prog);
    for (int f = 0; f < 7; f++) begin
      @(posedge clk);
      if (f == 6) en_n <= 1'b1;
      else if (f == 5) temp <= 8'h9b;
      else cond <= OK ^ (7'h40 >> f);
      repeat (4) @(negedge clk);
      chk(8'(chg), 8'h00);
      chk(iref, 8'h00);
      start(n);
      repeat (3) @(negedge clk);
      chk(iref, 8'(prog >> 3));
    end
    for (int g = 0; g < 2; g++) begin
      @(posedge clk);
      en_n <= 1'b1;
      @(posedge clk);
      cond <= OK ^ (7'h02 >> g);
      en_n <= 1'b0;
      repeat (6) @(negedge clk);
      chk(8'(chg), 8'h00);
    end
    foreach (tt[i]) begin
      @(posedge clk);
      temp <= tt[i];
      repeat (2) @(negedge clk);
      chk(8'(tsd), 8'(tf[i]));
    end
    start(n);
    for (int s = 1; s >= 0; s--) begin
      @(posedge clk);
      sync <= 1'(s);
      repeat (2) @(negedge clk);
      chk(8'(smode), 8'(s));
    end
    @(posedge clk);
    error_amp_output <= 6'($urandom_range(28, 4));
    sync <= 1'b1;
    rise(n);
    rise(n);
    rise(n);
    chk(8'(n), 8'h21);
    @(posedge clk);
    sync <= 1'b0;
    watch(99, h, r);
    chk(8'(r >= 2 && h > 0), 8'h01);
    @(posedge clk);
    error_amp_output <= 6'h00;
    sync <= 1'b1;
    repeat (10) @(posedge clk);
    watch(66, h, r);
    chk(8'(h), 8'h00);
    @(posedge clk);
    error_amp_output <= 6'h3f;
    repeat (40) @(posedge clk);
    watch(66, h, r);
    chk(8'(h), 8'h42);
    watch(400, h, r);
    chk(8'(r > 0 && h > 350), 8'h01);
    @(posedge clk);
    force_low <= 1'b1;
    repeat (200) @(posedge clk);
    watch(99, h, r);
    chk(8'(h == 0 && r > 0), 8'h01);
    conclude();
  end
endmodule : cesg_top_bench
bind cesg_top cesg_top_chk #(.PROG_W(PROG_W)) u_chk (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i),
  .charge_enable_low_input_i(charge_enable_low_input_i), .cond_i(cond_i),
  .die_temp_c_i(die_temp_c_i), .prog_current_i(prog_current_i),
  .error_amp_output_i(error_amp_output_i),
  .above_sync_threshold_i(above_sync_threshold_i), .charging_o(charging_o),
  .thermal_shutdown_o(thermal_shutdown_o), .sync_mode_o(sync_mode_o),
  .iref_o(iref_o), .hs_drive_o(hs_drive_o),
  .low_side_drive_o(low_side_drive_o));
`default_nettype wire
